// ---- rtl/app_status_pack.sv ----
module app_status_pack (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Condition flags from neighbouring functions
   input  wire logic        dry_pump_det,
   input  wire logic        broken_belt_det,
   input  wire logic        filter_maint_det,
   input  wire logic        int_ctrl_manual,
   input  wire logic        sleep_mode,
   input  wire logic        ext_ctrl_manual,
   // Packed word
   output logic [15:0]      status_word
);

   logic [15:0] word_r;
   logic [15:0] word_nxt;

   always_comb begin
      word_nxt = 16'h0000;                                   // see [R20]
      word_nxt[level_alarm_pkg::SB_DRY_PUMP]    = dry_pump_det;     // see [R10]
      word_nxt[level_alarm_pkg::SB_BROKEN_BELT] = broken_belt_det;  // see [R11]
      word_nxt[level_alarm_pkg::SB_FILTER]      = filter_maint_det; // see [R12]
      word_nxt[level_alarm_pkg::SB_INT_MANUAL]  = int_ctrl_manual;  // see [R13]
      word_nxt[level_alarm_pkg::SB_SLEEP]       = sleep_mode;       // see [R14]
      word_nxt[level_alarm_pkg::SB_EXT_MANUAL]  = ext_ctrl_manual;  // see [R15]
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         word_r <= 16'h0000;
      end else begin
         word_r <= word_nxt;
      end
   end

   assign status_word = word_r;

endmodule : app_status_pack

// ---- rtl/level_alarm_pkg.sv ----
// Functional notes
// [R01] Below signed low threshold means low level; default 2
// [R02] Low alarm after low qualification time elapses
// [R03] Action 2: low fault once motor stopped
// [R04] Zero low qualification time disables low detection
// [R05] Above signed high threshold means high level; default 900
// [R06] High alarm after high qualification time elapses
// [R07] Action 2: high fault once motor stopped
// [R08] Zero high qualification time disables high detection
// [R09] Read-only 16-bit application status word
// [R10] Bit 3 reports dry pump detected
// [R11] Bit 4 reports broken belt detected
// [R12] Bit 5 reports filter maintenance alarm
// [R13] Bit 6 reports internal controller manual mode
// [R14] Bit 7 reports drive in sleep mode
// [R15] Bit 8 reports external controller manual mode
// [R16] Action 0 suppresses both level alarms
// [R17] Action 1 reports alarm only, motor keeps running
// [R18] Action 2 alarm while decelerating, fault after stop
// [R19] Qualification timer restarts when condition clears early
// [R20] Reserved status bits always read zero
package level_alarm_pkg;

   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 4;

   // Register map, one 16-bit register per address
   localparam logic [3:0] ADDR_ACTION_CFG  = 4'h0;
   localparam logic [3:0] ADDR_LOW_THR     = 4'h1;
   localparam logic [3:0] ADDR_LOW_TIME    = 4'h2;
   localparam logic [3:0] ADDR_HIGH_THR    = 4'h3;
   localparam logic [3:0] ADDR_HIGH_TIME   = 4'h4;
   localparam logic [3:0] ADDR_APP_STATUS  = 4'h5;
   localparam logic [3:0] ADDR_EVENT_STAT  = 4'h6;
   localparam logic [3:0] ADDR_FAULT_CLR   = 4'h7;

   // Values after reset; times are in 10 ms units
   localparam logic [1:0]  RST_ACTION_CFG = 2'h0;
   localparam logic [15:0] RST_LOW_THR    = 16'h0002;
   localparam logic [15:0] RST_LOW_TIME   = 16'h01F4;
   localparam logic [15:0] RST_HIGH_THR   = 16'h0384;
   localparam logic [15:0] RST_HIGH_TIME  = 16'h01F4;
   localparam logic [15:0] MAX_QUAL_TIME  = 16'hFDE8;

   // Alarm action settings
   typedef enum logic [1:0] {
      ACT_DISABLE = 2'b00,
      ACT_ALARM   = 2'b01,
      ACT_FAULT   = 2'b10
   } alarm_action_e;

   // Application status word bit positions
   localparam int unsigned SB_DRY_PUMP    = 3;
   localparam int unsigned SB_BROKEN_BELT = 4;
   localparam int unsigned SB_FILTER      = 5;
   localparam int unsigned SB_INT_MANUAL  = 6;
   localparam int unsigned SB_SLEEP       = 7;
   localparam int unsigned SB_EXT_MANUAL  = 8;

   // Event status / fault clear bit positions
   localparam int unsigned EV_LOW_ALARM   = 0;
   localparam int unsigned EV_HIGH_ALARM  = 1;
   localparam int unsigned EV_LOW_FAULT   = 2;
   localparam int unsigned EV_HIGH_FAULT  = 3;
   localparam int unsigned EV_STOP_REQ    = 4;

   // Time base: qualification times count 10 ms ticks
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned TICK_TIME_NS   = 10000000;
   localparam int unsigned TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;

endpackage : level_alarm_pkg

// ---- rtl/level_qual_timer.sv ----
module level_qual_timer #(
   parameter int unsigned CNT_W = 16
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   // Qualification control
   input  wire logic             cond,
   input  wire logic             enable,
   input  wire logic             tick,
   input  wire logic [CNT_W-1:0] qual_time,
   // Result
   output logic                  qualified
);

   logic [CNT_W-1:0] cnt_r;
   logic             qual_r;
   logic             armed;

   generate
      if (CNT_W < 2) begin : g_bad_width
         $error("level_qual_timer: CNT_W must be at least 2");
      end
   endgenerate

   assign armed     = enable && cond && (qual_time != '0);
   assign qualified = qual_r;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= '0;
      end else if (!armed) begin
         cnt_r <= '0;                             // see [R19]
      end else if (tick && (cnt_r < qual_time)) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         qual_r <= 1'b0;
      end else begin
         // Compare with >= so lowering the time mid-count still fires
         qual_r <= armed && (cnt_r >= qual_time);  // see [R02] see [R06]
      end
   end

endmodule : level_qual_timer

// ---- rtl/process_level_alarm_monitor.sv ----
// Chosen here: the register offsets and the address-and-strobe port.
module process_level_alarm_monitor #(
   // Clock cycles per 10 ms qualification tick
   parameter int unsigned TICK_CYCLES = level_alarm_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   // Process variable and motor state
   input  wire logic [15:0] process_var,
   input  wire logic        motor_stopped,
   // Condition flags from neighbouring functions
   input  wire logic        dry_pump_det,
   input  wire logic        broken_belt_det,
   input  wire logic        filter_maint_det,
   input  wire logic        int_ctrl_manual,
   input  wire logic        sleep_mode,
   input  wire logic        ext_ctrl_manual,
   // Events towards the drive
   output logic             low_level_alarm_event,
   output logic             high_level_alarm_event,
   output logic             low_level_fault_event,
   output logic             high_level_fault_event,
   output logic             motor_stop_req,
   // Application status word
   output logic [15:0]      app_function_status_word
);

   localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);

   generate
      if (TICK_CYCLES < 1) begin : g_bad_tick
         $error("process_level_alarm_monitor: TICK_CYCLES must be >= 1");
      end
   endgenerate

   // Configuration registers
   logic [1:0]        level_alarm_action_cfg_r;
   logic signed [15:0] low_level_threshold_r;
   logic [15:0]       low_level_qual_time_r;
   logic signed [15:0] high_level_threshold_r;
   logic [15:0]       high_level_qual_time_r;

   // Time base
   logic [TICK_W-1:0] tick_cnt_r;
   logic              tick_r;

   // Level detection
   logic              low_cond_r;
   logic              high_cond_r;
   logic              alarm_en;
   logic              low_qual;
   logic              high_qual;

   // Event state
   logic              low_alarm_r;
   logic              high_alarm_r;
   logic              low_fault_r;
   logic              high_fault_r;
   logic              stop_req_r;
   logic              low_fault_nxt;
   logic              high_fault_nxt;

   // Bus read path
   logic [15:0]       status_word;
   logic [15:0]       event_word;
   logic [15:0]       rdata_r;
   logic [15:0]       rdata_nxt;
   logic              wr_cfg;
   logic              wr_fault_clr;
   logic              fault_mode;

   assign wr_cfg       = reg_wr;
   assign wr_fault_clr = reg_wr &&
                         (reg_addr == level_alarm_pkg::ADDR_FAULT_CLR);
   assign fault_mode   = (level_alarm_action_cfg_r ==
                          level_alarm_pkg::ACT_FAULT);

   // Configuration writes
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         level_alarm_action_cfg_r <= level_alarm_pkg::RST_ACTION_CFG;
      end else if (wr_cfg &&
                   (reg_addr == level_alarm_pkg::ADDR_ACTION_CFG)) begin
         level_alarm_action_cfg_r <= reg_wdata[1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         low_level_threshold_r <= level_alarm_pkg::RST_LOW_THR;
      end else if (wr_cfg &&
                   (reg_addr == level_alarm_pkg::ADDR_LOW_THR)) begin
         low_level_threshold_r <= reg_wdata;
      end
   end

   // Times above 650.00 s saturate to the top of the range
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         low_level_qual_time_r <= level_alarm_pkg::RST_LOW_TIME;
      end else if (wr_cfg &&
                   (reg_addr == level_alarm_pkg::ADDR_LOW_TIME)) begin
         if (reg_wdata > level_alarm_pkg::MAX_QUAL_TIME) begin
            low_level_qual_time_r <= level_alarm_pkg::MAX_QUAL_TIME;
         end else begin
            low_level_qual_time_r <= reg_wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         high_level_threshold_r <= level_alarm_pkg::RST_HIGH_THR;
      end else if (wr_cfg &&
                   (reg_addr == level_alarm_pkg::ADDR_HIGH_THR)) begin
         high_level_threshold_r <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         high_level_qual_time_r <= level_alarm_pkg::RST_HIGH_TIME;
      end else if (wr_cfg &&
                   (reg_addr == level_alarm_pkg::ADDR_HIGH_TIME)) begin
         if (reg_wdata > level_alarm_pkg::MAX_QUAL_TIME) begin
            high_level_qual_time_r <= level_alarm_pkg::MAX_QUAL_TIME;
         end else begin
            high_level_qual_time_r <= reg_wdata;
         end
      end
   end

   // 10 ms tick prescaler
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == TICK_W'(TICK_CYCLES - 1)) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
         tick_r     <= 1'b0;
      end
   end

   // Signed level comparisons, registered to cut the compare path
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         low_cond_r  <= 1'b0;
         high_cond_r <= 1'b0;
      end else begin
         low_cond_r  <= $signed(process_var) < low_level_threshold_r;  // see [R01]
         high_cond_r <= $signed(process_var) > high_level_threshold_r; // see [R05]
      end
   end

   // Action 0 and the unused code 3 keep both timers idle
   assign alarm_en = (level_alarm_action_cfg_r == level_alarm_pkg::ACT_ALARM)
                  || fault_mode;                                  // see [R16]

   // A zero time holds the timer idle inside the timer itself
   level_qual_timer #(
      .CNT_W (16)
   ) u_low_timer (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .cond      (low_cond_r),
      .enable    (alarm_en),
      .tick      (tick_r),
      .qual_time (low_level_qual_time_r),                        // see [R04]
      .qualified (low_qual)
   );

   level_qual_timer #(
      .CNT_W (16)
   ) u_high_timer (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .cond      (high_cond_r),
      .enable    (alarm_en),
      .tick      (tick_r),
      .qual_time (high_level_qual_time_r),                       // see [R08]
      .qualified (high_qual)
   );

   // Alarms follow the qualified condition in actions 1 and 2
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         low_alarm_r  <= 1'b0;
         high_alarm_r <= 1'b0;
      end else begin
         low_alarm_r  <= low_qual;                               // see [R02] see [R17]
         high_alarm_r <= high_qual;                              // see [R06] see [R17]
      end
   end

   // Faults latch once the motor has stopped; a new set beats a clear
   always_comb begin
      low_fault_nxt  = low_fault_r;
      high_fault_nxt = high_fault_r;
      if (wr_fault_clr && reg_wdata[level_alarm_pkg::EV_LOW_FAULT]) begin
         low_fault_nxt = 1'b0;
      end
      if (wr_fault_clr && reg_wdata[level_alarm_pkg::EV_HIGH_FAULT]) begin
         high_fault_nxt = 1'b0;
      end
      if (fault_mode && low_alarm_r && motor_stopped) begin
         low_fault_nxt = 1'b1;                                   // see [R03]
      end
      if (fault_mode && high_alarm_r && motor_stopped) begin
         high_fault_nxt = 1'b1;                                  // see [R07]
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         low_fault_r  <= 1'b0;
         high_fault_r <= 1'b0;
      end else begin
         low_fault_r  <= low_fault_nxt;
         high_fault_r <= high_fault_nxt;
      end
   end

   // In action 2 the drive ramps down while the alarm stands, and
   // stays stopped as long as a fault is latched
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stop_req_r <= 1'b0;
      end else begin
         stop_req_r <= (fault_mode && (low_alarm_r || high_alarm_r))
                    || low_fault_r || high_fault_r;             // see [R18]
      end
   end

   // Status word assembly
   app_status_pack u_status (
      .ref_clk          (ref_clk),
      .resetn           (resetn),
      .dry_pump_det     (dry_pump_det),
      .broken_belt_det  (broken_belt_det),
      .filter_maint_det (filter_maint_det),
      .int_ctrl_manual  (int_ctrl_manual),
      .sleep_mode       (sleep_mode),
      .ext_ctrl_manual  (ext_ctrl_manual),
      .status_word      (status_word)
   );

   always_comb begin
      event_word = 16'h0000;
      event_word[level_alarm_pkg::EV_LOW_ALARM]  = low_alarm_r;
      event_word[level_alarm_pkg::EV_HIGH_ALARM] = high_alarm_r;
      event_word[level_alarm_pkg::EV_LOW_FAULT]  = low_fault_r;
      event_word[level_alarm_pkg::EV_HIGH_FAULT] = high_fault_r;
      event_word[level_alarm_pkg::EV_STOP_REQ]   = stop_req_r;
   end

   // Read mux; unmapped addresses and the write-only clear read zero
   always_comb begin
      case (reg_addr)
         level_alarm_pkg::ADDR_ACTION_CFG:
            rdata_nxt = {14'h0000, level_alarm_action_cfg_r};
         level_alarm_pkg::ADDR_LOW_THR:
            rdata_nxt = low_level_threshold_r;
         level_alarm_pkg::ADDR_LOW_TIME:
            rdata_nxt = low_level_qual_time_r;
         level_alarm_pkg::ADDR_HIGH_THR:
            rdata_nxt = high_level_threshold_r;
         level_alarm_pkg::ADDR_HIGH_TIME:
            rdata_nxt = high_level_qual_time_r;
         level_alarm_pkg::ADDR_APP_STATUS:
            rdata_nxt = status_word;                             // see [R09]
         level_alarm_pkg::ADDR_EVENT_STAT:
            rdata_nxt = event_word;
         default:
            rdata_nxt = 16'h0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= 16'h0000;
      end else if (reg_rd) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 16'h0000;
      end
   end

   assign reg_rdata                = rdata_r;
   assign low_level_alarm_event    = low_alarm_r;
   assign high_level_alarm_event   = high_alarm_r;
   assign low_level_fault_event    = low_fault_r;
   assign high_level_fault_event   = high_fault_r;
   assign motor_stop_req           = stop_req_r;
   assign app_function_status_word = status_word;

endmodule : process_level_alarm_monitor

// ---- tb/level_alarm_assertions.sv ----
module level_alarm_assertions (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        resetn,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   // Process side
   input wire logic [15:0] process_var,
   input wire logic        motor_stopped,
   input wire logic        dry_pump_det,
   input wire logic        broken_belt_det,
   input wire logic        filter_maint_det,
   input wire logic        int_ctrl_manual,
   input wire logic        sleep_mode,
   input wire logic        ext_ctrl_manual,
   // Monitor outputs
   input wire logic        low_level_alarm_event,
   input wire logic        high_level_alarm_event,
   input wire logic        low_level_fault_event,
   input wire logic        high_level_fault_event,
   input wire logic        motor_stop_req,
   input wire logic [15:0] app_function_status_word
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   // Shadow settings, so level conditions can be judged from the ports
   logic [1:0]  cfg_r;
   logic [15:0] lo_thr_r;
   logic [15:0] hi_thr_r;
   wire logic   lo_c = $signed(process_var) < $signed(lo_thr_r);
   wire logic   hi_c = $signed(process_var) > $signed(hi_thr_r);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_r    <= 2'h0;
         lo_thr_r <= 16'h0002;
         hi_thr_r <= 16'h0384;
      end else if (reg_wr) begin
         case (reg_addr)
            level_alarm_pkg::ADDR_ACTION_CFG: cfg_r    <= reg_wdata[1:0];
            level_alarm_pkg::ADDR_LOW_THR:    lo_thr_r <= reg_wdata;
            level_alarm_pkg::ADDR_HIGH_THR:   hi_thr_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   property p_rdata_idle;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside a read");

   property p_reserved;
      app_function_status_word[2:0] == 3'h0
         && app_function_status_word[15:9] == 7'h00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved status bits not zero");

   property p_status_bits;
      $past(resetn) |-> app_function_status_word[8:3] == $past({
         ext_ctrl_manual, sleep_mode, int_ctrl_manual,
         filter_maint_det, broken_belt_det, dry_pump_det});
   endproperty
   a_status_bits: assert property (p_status_bits)
      else $error("status word bits 3 to 8 do not follow flags");

   property p_low_fault;
      $rose(low_level_fault_event)
         |-> $past(motor_stopped && low_level_alarm_event && cfg_r == 2'h2);
   endproperty
   a_low_fault: assert property (p_low_fault)
      else $error("low fault without alarm, stop and action 2");

   property p_high_fault;
      $rose(high_level_fault_event)
         |-> $past(motor_stopped && high_level_alarm_event && cfg_r == 2'h2);
   endproperty
   a_high_fault: assert property (p_high_fault)
      else $error("high fault without alarm, stop and action 2");

   property p_low_cond;
      $rose(low_level_alarm_event) |-> $past(lo_c, 2);
   endproperty
   a_low_cond: assert property (p_low_cond)
      else $error("low alarm rose without low level");

   property p_high_cond;
      $rose(high_level_alarm_event) |-> $past(hi_c, 2);
   endproperty
   a_high_cond: assert property (p_high_cond)
      else $error("high alarm rose without high level");

   property p_low_drop;
      (!lo_c) [*5] |-> !low_level_alarm_event;
   endproperty
   a_low_drop: assert property (p_low_drop)
      else $error("low alarm stays after level cleared");

   property p_cfg_off;
      (cfg_r == 2'h0 || cfg_r == 2'h3) [*5]
         |-> !(low_level_alarm_event || high_level_alarm_event);
   endproperty
   a_cfg_off: assert property (p_cfg_off)
      else $error("level alarm while alarms disabled");

   property p_stop_req;
      motor_stop_req == $past(low_level_fault_event || high_level_fault_event
         || (cfg_r == 2'h2
             && (low_level_alarm_event || high_level_alarm_event)));
   endproperty
   a_stop_req: assert property (p_stop_req)
      else $error("stop request does not match action and events");
endmodule : level_alarm_assertions

bind process_level_alarm_monitor level_alarm_assertions
   level_alarm_assertions_i (
   .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .process_var(process_var),
   .motor_stopped(motor_stopped), .dry_pump_det(dry_pump_det),
   .broken_belt_det(broken_belt_det), .filter_maint_det(filter_maint_det),
   .int_ctrl_manual(int_ctrl_manual), .sleep_mode(sleep_mode),
   .ext_ctrl_manual(ext_ctrl_manual),
   .low_level_alarm_event(low_level_alarm_event),
   .high_level_alarm_event(high_level_alarm_event),
   .low_level_fault_event(low_level_fault_event),
   .high_level_fault_event(high_level_fault_event),
   .motor_stop_req(motor_stop_req),
   .app_function_status_word(app_function_status_word));

// ---- tb/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic        ref_clk;
   logic        resetn;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic [15:0] process_var;
   logic        motor_stopped;
   logic [5:0]  flags;
   logic        rd_seen;
   logic [31:0] seed;
   logic [15:0] exp_q[$];
   int          checked = 0;
   int          fail_count = 0;

   process_level_alarm_monitor #(.TICK_CYCLES(2))
      process_level_alarm_monitor_i (
      .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .process_var(process_var),
      .motor_stopped(motor_stopped), .dry_pump_det(flags[0]),
      .broken_belt_det(flags[1]), .filter_maint_det(flags[2]),
      .int_ctrl_manual(flags[3]), .sleep_mode(flags[4]),
      .ext_ctrl_manual(flags[5]), .low_level_alarm_event(),
      .high_level_alarm_event(), .low_level_fault_event(),
      .high_level_fault_event(), .motor_stop_req(),
      .app_function_status_word());

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : idle

   // Strobes drop with a gap cycle so no signal is driven twice per step
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      @(posedge ref_clk);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      @(posedge ref_clk);
   endtask : rd

   task automatic ev(input logic [15:0] e);
      rd(level_alarm_pkg::ADDR_EVENT_STAT, e);
   endtask : ev

   task automatic cmp(input logic [15:0] got, input logic [15:0] e);
      checked++;
      if (got !== e) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask : cmp

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge ref_clk) begin
      if (rd_seen === 1'b1) begin
         cmp(reg_rdata, exp_q.pop_front());
      end
      rd_seen <= reg_rd;
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      $display("BAD t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
      tally_and_finish();
   end

   initial begin
      resetn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      process_var = 16'h0100;
      motor_stopped = 1'b0;
      flags = 6'h00;
      rd_seen = 1'b0;
      seed = 32'h44876DB5;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      rd(level_alarm_pkg::ADDR_ACTION_CFG, 16'h0000);
      rd(level_alarm_pkg::ADDR_LOW_THR, 16'h0002);
      rd(level_alarm_pkg::ADDR_LOW_TIME, 16'h01F4);
      rd(level_alarm_pkg::ADDR_HIGH_THR, 16'h0384);
      rd(level_alarm_pkg::ADDR_HIGH_TIME, 16'h01F4);
      rd(4'h9, 16'h0000);
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         flags <= seed[5:0];
         idle(2);
         rd(level_alarm_pkg::ADDR_APP_STATUS, {7'h00, seed[5:0], 3'h0});
      end
      wr(level_alarm_pkg::ADDR_APP_STATUS, 16'hFFFF);
      rd(level_alarm_pkg::ADDR_APP_STATUS, {7'h00, flags, 3'h0});
      $display("test status word done");
      // Negative threshold: an unsigned compare would see 0 as below it
      wr(level_alarm_pkg::ADDR_LOW_THR, 16'hFF9C);
      wr(level_alarm_pkg::ADDR_LOW_TIME, 16'hFFFF);
      rd(level_alarm_pkg::ADDR_LOW_TIME, 16'hFDE8);
      wr(level_alarm_pkg::ADDR_LOW_TIME, 16'h0003);
      for (int c = 0; c < 4; c++) begin
         wr(level_alarm_pkg::ADDR_ACTION_CFG, 16'(c));
         process_var <= 16'hFF9B;
         idle(20);
         ev((c == 1) ? 16'h0001 : (c == 2) ? 16'h0011 : 16'h0000);
         process_var <= 16'h0000;
         idle(10);
         ev(16'h0000);
      end
      $display("test action codes done");
      wr(level_alarm_pkg::ADDR_ACTION_CFG, 16'h0001);
      wr(level_alarm_pkg::ADDR_LOW_TIME, 16'h0005);
      for (int i = 0; i < 3; i++) begin
         process_var <= 16'hFF9B;
         idle(5);
         ev(16'h0000);
         process_var <= 16'h0000;
         idle(1);
      end
      process_var <= 16'hFF9B;
      idle(20);
      ev(16'h0001);
      wr(level_alarm_pkg::ADDR_LOW_TIME, 16'h0000);
      idle(20);
      ev(16'h0000);
      process_var <= 16'h0000;
      $display("test low timing done");
      wr(level_alarm_pkg::ADDR_HIGH_TIME, 16'h0000);
      wr(level_alarm_pkg::ADDR_HIGH_THR, 16'hFFFB);
      idle(20);
      ev(16'h0000);
      wr(level_alarm_pkg::ADDR_HIGH_TIME, 16'h0002);
      idle(20);
      ev(16'h0002);
      wr(level_alarm_pkg::ADDR_HIGH_THR, 16'h0384);
      idle(10);
      ev(16'h0000);
      $display("test high level done");
      wr(level_alarm_pkg::ADDR_ACTION_CFG, 16'h0002);
      wr(level_alarm_pkg::ADDR_LOW_TIME, 16'h0002);
      process_var <= 16'hFF9B;
      idle(20);
      ev(16'h0011);
      motor_stopped <= 1'b1;
      idle(4);
      ev(16'h0015);
      process_var <= 16'h0000;
      idle(10);
      ev(16'h0014);
      wr(level_alarm_pkg::ADDR_FAULT_CLR, 16'h0004);
      ev(16'h0000);
      process_var <= 16'h0400;
      idle(20);
      ev(16'h001A);
      process_var <= 16'h0000;
      idle(10);
      wr(level_alarm_pkg::ADDR_FAULT_CLR, 16'h0008);
      ev(16'h0000);
      motor_stopped <= 1'b0;
      $display("test faults done");
      idle(3);
      if (exp_q.size() != 0) begin
         fail_count++;
      end
      tally_and_finish();
   end
endmodule : testbench
